// ### rtl/bfr_ctrl.sv
// module: background flash reprogram control, core and serial test port logic
module bfr_ctrl
#(
    parameter int CONFIG_CYCLES_P = bfr_pkg::CONFIG_CYCLES
)
(
    input  wire logic MCLK,
    input  wire logic ARST_N,
    input  wire logic TEST_CLK,
    input  wire logic TEST_MODE_SEL,
    input  wire logic TEST_DATA_IN,
    input  wire logic FLASH_PROG_DONE,
    output logic      TEST_DATA_OUT,
    output logic      TEST_DATA_OE,
    output logic      USER_MODE,
    output logic      IO_HIZ,
    output logic      IO_PULLUP,
    output logic      LOGIC_RESET_N,
    output logic      SRAM_LOAD,
    output logic      FLASH_PROG_EN,
    output logic      IMAGE_PENDING
);

    typedef enum logic [2:0]
    {
        ST_POWERUP,
        ST_USER,
        ST_PROG_NORM,
        ST_PROG_BKGD,
        ST_COPY,
        ST_RESET
    } bfr_state_t;

    // ------------------------------------------------------------
    // serial test port (link clock)
    // ------------------------------------------------------------
    // simplified shift path: mode-select high loads shift reg into instruction
    logic [bfr_pkg::IR_W-1:0] shift_reg;
    logic [bfr_pkg::IR_W-1:0] instr;
    bfr_pkg::bfr_link_t       link;
    logic                     tdo_q;
    logic                     shifting;

    wire logic [bfr_pkg::IR_W-1:0] next_shift = {TEST_DATA_IN, shift_reg[bfr_pkg::IR_W-1:1]};
    wire logic load_ir  = TEST_MODE_SEL;
    wire logic ins_prog = load_ir && (shift_reg == bfr_pkg::INS_PROG);
    wire logic ins_done = load_ir && (shift_reg == bfr_pkg::INS_DONE);

    always_ff @(posedge TEST_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            shift_reg <= bfr_pkg::IR_RESET_VAL;
            instr     <= bfr_pkg::IR_RESET_VAL;
            link      <= '0;
            shifting  <= 1'b0;
        end
        else
        begin
            // inputs taken only on the rising edge
            shift_reg <= load_ir ? shift_reg : next_shift;
            shifting  <= !load_ir;
            if (load_ir)
                instr <= shift_reg;
            if (load_ir && shift_reg == bfr_pkg::INS_SEL_BKGD)
                link.mode_bkgd <= 1'b1;
            if (load_ir && shift_reg == bfr_pkg::INS_SEL_NORM)
                link.mode_bkgd <= 1'b0;
            if (ins_prog)
                link.prog_tgl <= ~link.prog_tgl;
            if (ins_done)
                link.done_tgl <= ~link.done_tgl;
        end
    end

    // output launched half a cycle later so host samples stable data
    always_ff @(negedge TEST_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tdo_q        <= 1'b0;
            TEST_DATA_OE <= 1'b0;
        end
        else
        begin
            tdo_q        <= shift_reg[0];
            TEST_DATA_OE <= shifting;
        end
    end

    assign TEST_DATA_OUT = tdo_q;

    // ------------------------------------------------------------
    // crossing into MCLK: three stages, act when second and third agree
    // ------------------------------------------------------------
    bfr_pkg::bfr_link_t s1;
    bfr_pkg::bfr_link_t s2;
    bfr_pkg::bfr_link_t s3;
    bfr_pkg::bfr_link_t seen;
    logic               done_s1;
    logic               done_s2;
    logic               done_s3;

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s1      <= '0;
            s2      <= '0;
            s3      <= '0;
            seen    <= '0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end
        else
        begin
            s1      <= link;
            s2      <= s1;
            s3      <= s2;
            done_s1 <= FLASH_PROG_DONE;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            if (s2 == s3)
                seen <= s3;
        end
    end

    wire logic stable    = (s2 == s3);
    wire logic prog_req  = stable && (s3.prog_tgl != seen.prog_tgl);
    wire logic done_req  = stable && (s3.done_tgl != seen.done_tgl);
    wire logic flash_ok  = done_s2 && done_s3;
    wire logic mode_bkgd = s3.mode_bkgd && s2.mode_bkgd;

    // ------------------------------------------------------------
    // core sequencer (MCLK)
    // ------------------------------------------------------------
    bfr_state_t                 state;
    bfr_state_t                 next_state;
    bfr_pkg::bfr_mode_t         mode;
    logic [bfr_pkg::CNT_W-1:0]  cnt;
    logic                       pending;
    bfr_pkg::bfr_stat_t         stat;
    bfr_pkg::bfr_stat_t         next_stat;

    wire logic [bfr_pkg::CNT_W-1:0] load_cnt = bfr_pkg::CNT_W'(CONFIG_CYCLES_P);
    wire logic cnt_done = (cnt == bfr_pkg::CNT_ONE);
    wire logic finished = flash_ok || done_req;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_POWERUP:
                if (cnt_done)
                    next_state = ST_USER;
            ST_USER:
                if (prog_req)
                    next_state = mode_bkgd ? ST_PROG_BKGD : ST_PROG_NORM;
            ST_PROG_NORM:
                if (finished)
                    next_state = ST_COPY;
            ST_PROG_BKGD:
                if (finished)
                    next_state = ST_USER;
            ST_COPY:
                if (cnt_done)
                    next_state = ST_RESET;
            ST_RESET:
                next_state = ST_USER;
            default:
                next_state = ST_POWERUP;
        endcase
    end

    // pins: tri-state and pulled up only for a normal session
    wire logic norm_busy = (next_state == ST_PROG_NORM) || (next_state == ST_COPY);
    wire logic user_live = (next_state == ST_USER) || (next_state == ST_PROG_BKGD);
    wire logic prog_busy = (next_state == ST_PROG_NORM) || (next_state == ST_PROG_BKGD);
    // one driver for the whole struct: order is user, hiz, pullup, busy
    assign next_stat = {user_live, norm_busy, norm_busy, prog_busy};

    wire logic enter_load = (state == ST_PROG_NORM) && finished;

    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state <= ST_POWERUP;
            cnt   <= bfr_pkg::CNT_ZERO;
            mode  <= bfr_pkg::BFR_MODE_NORMAL;
            stat  <= '0;
        end
        else
        begin
            state <= next_state;
            stat  <= next_stat;
            if (state == ST_POWERUP && cnt == bfr_pkg::CNT_ZERO)
                cnt <= load_cnt;
            else if (enter_load)
                cnt <= load_cnt;
            else if (cnt != bfr_pkg::CNT_ZERO)
                cnt <= cnt - bfr_pkg::CNT_ONE;
            if (state == ST_USER && prog_req)
                mode <= mode_bkgd ? bfr_pkg::BFR_MODE_BACKGROUND
                                  : bfr_pkg::BFR_MODE_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // pending image only clears by power cycle, i.e. the async reset
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pending       <= 1'b0;
            SRAM_LOAD     <= 1'b0;
            LOGIC_RESET_N <= 1'b0;
        end
        else
        begin
            if (state == ST_PROG_BKGD && finished && mode == bfr_pkg::BFR_MODE_BACKGROUND)
                pending <= 1'b1;
            SRAM_LOAD     <= (next_state == ST_POWERUP) || (next_state == ST_COPY);
            LOGIC_RESET_N <= (next_state == ST_USER) || (next_state == ST_PROG_BKGD);
        end
    end

    assign USER_MODE     = stat.user_mode;
    assign IO_HIZ        = stat.io_hiz;
    assign IO_PULLUP     = stat.io_pullup;
    assign FLASH_PROG_EN = stat.flash_busy;
    assign IMAGE_PENDING = pending;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_copy_after_prog;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_COPY && $past(state) != ST_COPY) |-> $past(state) == ST_PROG_NORM;
    endproperty
    a_copy_after_prog: assert property (p_copy_after_prog) else $error("copy without program");

    property p_hiz_norm;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_PROG_NORM || state == ST_COPY) |-> IO_HIZ && IO_PULLUP;
    endproperty
    a_hiz_norm: assert property (p_hiz_norm) else $error("pins not tri-stated");

    property p_reset_after_copy;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_COPY && cnt_done) |=> state == ST_RESET ##1 state == ST_USER;
    endproperty
    a_reset_after_copy: assert property (p_reset_after_copy) else $error("no reset after copy");

    property p_bkgd_live;
        @(posedge MCLK) disable iff (!ARST_N)
        state == ST_PROG_BKGD |=> USER_MODE && !IO_HIZ && LOGIC_RESET_N;
    endproperty
    a_bkgd_live: assert property (p_bkgd_live) else $error("background stalled");

    property p_bkgd_no_copy;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_PROG_BKGD && finished) |=> state == ST_USER ##1 !SRAM_LOAD;
    endproperty
    a_bkgd_no_copy: assert property (p_bkgd_no_copy) else $error("background copied");

    property p_pending_sticks;
        @(posedge MCLK) disable iff (!ARST_N)
        IMAGE_PENDING |=> IMAGE_PENDING;
    endproperty
    a_pending_sticks: assert property (p_pending_sticks) else $error("pending lost");

    property p_powerup_load;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_POWERUP && !cnt_done) |=> !USER_MODE;
    endproperty
    a_powerup_load: assert property (p_powerup_load) else $error("early user mode");

    property p_mode_latched;
        @(posedge MCLK) disable iff (!ARST_N)
        (state == ST_USER && prog_req && mode_bkgd) |=> mode == bfr_pkg::BFR_MODE_BACKGROUND
            && state == ST_PROG_BKGD;
    endproperty
    a_mode_latched: assert property (p_mode_latched) else $error("mode not latched");

    property p_tdo_hold;
        @(negedge TEST_CLK) disable iff (!ARST_N)
        1'b1 |=> TEST_DATA_OUT == $past(shift_reg[0]);
    endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("output not launched on fall");

endmodule

// ### rtl/bfr_pkg.sv
// package: shared types and constants for the background flash reprogram control
package bfr_pkg;

    // programming session mode
    typedef enum logic
    {
        BFR_MODE_NORMAL,
        BFR_MODE_BACKGROUND
    } bfr_mode_t;

    // instruction register layout on the serial test port
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_RESET_VAL  = 4'h1;
    localparam logic [3:0]  INS_SEL_NORM  = 4'h2;
    localparam logic [3:0]  INS_SEL_BKGD  = 4'h3;
    localparam logic [3:0]  INS_PROG      = 4'h4;
    localparam logic [3:0]  INS_DONE      = 4'h5;

    // configuration load time at power-up and for the copy after a normal session
    localparam int          T_CONFIG_NS   = 300000;
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          CONFIG_CYCLES = (T_CONFIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_ONE       = 16'h0001;

    // events that cross from the test clock domain
    typedef struct packed
    {
        logic mode_bkgd;
        logic prog_tgl;
        logic done_tgl;
    } bfr_link_t;

    // what the core shows to the fabric and pins
    typedef struct packed
    {
        logic user_mode;
        logic io_hiz;
        logic io_pullup;
        logic flash_busy;
    } bfr_stat_t;

endpackage

// ### bench/bfr_host.sv
// partner model: programming host on the serial test port
module bfr_host
(
    output logic      TEST_CLK,
    output logic      TEST_MODE_SEL,
    output logic      TEST_DATA_IN,
    input  wire logic TEST_DATA_OUT,
    input  wire logic TEST_DATA_OE
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] echo;

    // ------------------------------------------------------------
    // test clock stands still between frames
    // ------------------------------------------------------------
    initial
    begin
        TEST_CLK = 1'b0;
        TEST_MODE_SEL = 1'b0;
        TEST_DATA_IN = 1'b1;
        echo = 2'b00;
    end

    // inputs change while clock low, device samples on the rise
    task automatic tick(input logic sel, input logic din);
        TEST_MODE_SEL = sel;
        TEST_DATA_IN = din;
        #24;
        // on the load tick only, serial output and enable read just before the rise
        if (sel)
            echo = {TEST_DATA_OE, TEST_DATA_OUT};
        TEST_CLK = 1'b1;
        #24 TEST_CLK = 1'b0;
    endtask

    // four bits lsb first, load, then two spare cycles before release
    task automatic send(input logic [3:0] code);
        for (int i = 0; i < 4; i++)
            tick(1'b0, code[i]);
        tick(1'b1, ~code[3]);
        tick(1'b0, code[3]);
        tick(1'b0, ~code[3]);
        #24 TEST_DATA_IN = ~TEST_DATA_IN;  // released line must not look held
    endtask
endmodule

// ### bench/tb.sv
// testbench: power-up, refused requests, background and normal sessions
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CFG = 20;
    logic       MCLK, ARST_N, FLASH_PROG_DONE;
    wire        tck, tms, tdi, tdo, toe;
    wire        user_mode, io_hiz, io_pullup, rst_n, sram_load, prog_en, img_pend;
    logic [6:0] q[$];
    logic [6:0] st, prev;
    int         fail_count, tests_run, ld_len;

    bfr_ctrl #(.CONFIG_CYCLES_P(CFG)) uut
    (
        .MCLK(MCLK), .ARST_N(ARST_N), .TEST_CLK(tck), .TEST_MODE_SEL(tms),
        .TEST_DATA_IN(tdi), .FLASH_PROG_DONE(FLASH_PROG_DONE), .TEST_DATA_OUT(tdo),
        .TEST_DATA_OE(toe), .USER_MODE(user_mode), .IO_HIZ(io_hiz), .IO_PULLUP(io_pullup),
        .LOGIC_RESET_N(rst_n), .SRAM_LOAD(sram_load), .FLASH_PROG_EN(prog_en),
        .IMAGE_PENDING(img_pend)
    );

    bfr_host host
    (
        .TEST_CLK(tck), .TEST_MODE_SEL(tms), .TEST_DATA_IN(tdi),
        .TEST_DATA_OUT(tdo), .TEST_DATA_OE(toe)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // bounded wait for every noted result to show up
    task automatic drain(input int lim);
        int n;
        n = 0;
        while (q.size() != 0 && n < lim)
        begin
            @(posedge MCLK);
            n++;
        end
        if (q.size() != 0)
            check(7'h7F, q.pop_front());
        q.delete();
    endtask

    // after four shifts the load sees the oldest bit out, enable high
    task automatic issue(input logic [3:0] code);
        host.send(code);
        check({5'h00, host.echo}, {5'h00, 1'b1, code[0]});
    endtask

    // test clock must see an edge inside reset
    task automatic power_cycle;
        @(posedge MCLK) #2 ARST_N = 1'b0;
        host.tick(1'b0, 1'b1);
        repeat (10) @(posedge MCLK);
        q.push_back(7'h04);
        q.push_back(7'h48);
        #2 ARST_N = 1'b1;
        drain(CFG + 60);
    endtask

    // completion by the flag pin or by instruction
    task automatic finish_prog(input bit by_pin, input int lim);
        if (by_pin)
        begin
            @(posedge MCLK) #2 FLASH_PROG_DONE = 1'b1;
            drain(lim);
            @(posedge MCLK) #2 FLASH_PROG_DONE = 1'b0;
        end
        else
        begin
            issue(bfr_pkg::INS_DONE);
            drain(lim);
        end
    endtask

    // ------------------------------------------------------------
    // monitor: each status change except to the all-low state consumes the oldest note
    // ------------------------------------------------------------
    always @(negedge MCLK)
    begin
        st = {user_mode, io_hiz, io_pullup, rst_n, sram_load, prog_en, img_pend};
        if (ARST_N !== 1'b1)
            prev = 7'h00;
        else if (st !== prev)
        begin
            // the one-cycle all-low reset state is not a result of its own
            if (st !== 7'h00)
            begin
                if (q.size() == 0)
                    check(st, prev);
                else
                    check(st, q.pop_front());
            end
            prev = st;
        end
        if (sram_load === 1'b1)
            ld_len++;
        else if (ld_len != 0)
        begin
            check(7'(ld_len >= CFG), 7'h01);
            ld_len = 0;
        end
    end

    // serial output only moves while the test clock is low
    always @(tdo or toe)
        if (ARST_N === 1'b1)
            check({6'h00, tck}, 7'h00);

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial
    begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    initial
    begin
        repeat (20000) @(posedge MCLK);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        ARST_N = 1'b0;
        FLASH_PROG_DONE = 1'b0;
        fail_count = 0;
        tests_run = 0;
        ld_len = 0;
        prev = 7'h00;
        void'($urandom(81122));
        power_cycle();
        issue(bfr_pkg::INS_DONE);  // refused outside a session
        repeat (20) @(posedge MCLK);
        issue(bfr_pkg::INS_SEL_BKGD);
        q.push_back(7'h4A);
        issue(bfr_pkg::INS_PROG);
        drain(50);
        issue(bfr_pkg::INS_SEL_NORM);
        q.push_back(7'h49);
        finish_prog(1'($urandom_range(1, 0)), 50);
        repeat ($urandom_range(60, 20)) @(posedge MCLK);
        power_cycle();
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1)
                issue(bfr_pkg::INS_SEL_NORM);
            q.push_back(7'h32);
            issue(bfr_pkg::INS_PROG);
            drain(50);
            repeat ($urandom_range(30, 5)) @(posedge MCLK);
            q.push_back(7'h34);
            q.push_back(7'h48);
            finish_prog(k[0], CFG + 60);
        end
        tally_and_finish();
    end
endmodule
